/* File: rtl/asp_regs.svh */
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_HALF_W    16
`define ASP_WORD_W    32
`define ASP_CNT_W     6
`define ASP_LEN_16    6'h10
`define ASP_LEN_18    6'h12
`define ASP_LEN_20    6'h14
`define ASP_LEN_24    6'h18
`define ASP_LEN_32    6'h20
`define ASP_FLAGS_RST 6'h00
`define ASP_WORD_RST  32'h0000_0000
`define ASP_HALF_RST  16'h0000
`endif

/* File: rtl/asp_pkg.sv */
`include "asp_regs.svh"
package asp_pkg;
    typedef enum logic [2:0] {ASP_W16, ASP_W18, ASP_W20, ASP_W24, ASP_W32} asp_wlen_e;
    typedef enum logic {ASP_IDLE, ASP_SHIFT} asp_state_e;
    typedef struct packed {
        logic      enable;
        logic      mono;
        logic      frame_format_select;
        logic      two_samples_per_pair;
        logic      msb_replicate_select;
        asp_wlen_e wlen;
    } asp_ctrl_s;
    typedef struct packed {
        logic [`ASP_HALF_W-1:0] hi;
        logic [`ASP_HALF_W-1:0] lo;
    } asp_pair_s;
    typedef struct packed {
        asp_pair_s left;
        asp_pair_s right;
    } asp_stereo_s;
    typedef struct packed {
        logic overrun_underrun_error;
        logic fsync_error;
        logic rx_stereo;
        logic tx_stereo;
        logic rx_mono;
        logic tx_mono;
    } asp_irq_s;
endpackage

/* File: rtl/asp_word_two_samples_per_pair.sv */
// Summary of operation
// - 16-bit: sample high, low zero; two_samples_per_pair older-high
// - 18-bit layouts, sign copies bit 17
// - 20-bit layouts, sign copies bit 19
// - 24-bit layouts, sign copies bit 23
// - 32-bit: upper half high, lower low
// - soft reset spares shift registers
// - hardware reset restores every register default
// - tx, rx, two error interrupts, maskable
// - separate stereo and mono enable bits
// - every interrupt condition sets a flag
// - stereo events after right channel word
// - mono moves left only in dsp format, event after left
// - first error after enable may be spurious
// - dma events ignore the mask
// - reading flags clears returned flags
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
module asp_word_two_samples_per_pair
    import asp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        peripheral_reset_control,
    input  wire asp_ctrl_s   ctrl,
    input  wire asp_irq_s    interrupt_mask_reg,
    input  wire asp_stereo_s tx_data,
    input  wire logic        tx_data_valid,
    input  wire logic        rx_data_read,
    input  wire logic        flag_read,
    input  wire logic        bclk_pin,
    input  wire logic        fsync_pin,
    input  wire logic        sdin_pin,
    output logic             sdout,
    output asp_stereo_s      rx_data,
    output asp_irq_s         interrupt_flag_reg,
    output logic             cpu_irq,
    output logic             tx_dma_evt,
    output logic             rx_dma_evt
);

    // ------------------------------------------------------------
    // word layout helpers
    // ------------------------------------------------------------
    function automatic logic [`ASP_CNT_W-1:0] wlen_bits(input asp_wlen_e w);
        unique case (w)
            ASP_W16: wlen_bits = `ASP_LEN_16;
            ASP_W18: wlen_bits = `ASP_LEN_18;
            ASP_W20: wlen_bits = `ASP_LEN_20;
            ASP_W24: wlen_bits = `ASP_LEN_24;
            ASP_W32: wlen_bits = `ASP_LEN_32;
            default: wlen_bits = `ASP_LEN_16;
        endcase
    endfunction

    // right-aligned only for 18/20/24 with sign copies
    function automatic logic right_aligned(input asp_wlen_e w, input logic sext);
        right_aligned = sext && (w == ASP_W18 || w == ASP_W20 || w == ASP_W24);
    endfunction

    // left-aligned received sample into register pair
    function automatic asp_pair_s rx_place(
        input logic [`ASP_WORD_W-1:0] smp,
        input asp_wlen_e              w,
        input logic                   sext,
        input logic                   two_samples_per_pair_on,
        input logic                   phase,
        input asp_pair_s              old
    );
        logic [`ASP_CNT_W-1:0] sh;
        sh = `ASP_LEN_32 - wlen_bits(w);
        rx_place = smp;
        if (right_aligned(w, sext)) begin
            rx_place = $signed(smp) >>> sh;
        end
        if (two_samples_per_pair_on) begin
            rx_place = phase ? {old.hi, smp[31:16]} : {smp[31:16], `ASP_HALF_RST};
        end
    endfunction

    // register pair into msb-first shift word; sign bits dropped
    function automatic logic [`ASP_WORD_W-1:0] tx_align(
        input asp_pair_s p,
        input asp_wlen_e w,
        input logic      sext,
        input logic      two_samples_per_pair_on,
        input logic      phase
    );
        logic [`ASP_CNT_W-1:0] sh;
        sh = `ASP_LEN_32 - wlen_bits(w);
        tx_align = p;
        if (right_aligned(w, sext)) begin
            tx_align = p << sh;
        end
        if (two_samples_per_pair_on) begin
            tx_align = {(phase ? p.lo : p.hi), `ASP_HALF_RST};
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic bclk_s1_ff;
    logic bclk_s2_ff;
    logic bclk_s3_ff;
    logic fs_s1_ff;
    logic fs_s2_ff;
    logic fs_last_ff;
    logic sd_s1_ff;
    logic sd_s2_ff;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            {bclk_s1_ff, bclk_s2_ff, bclk_s3_ff} <= 3'h0;
            {fs_s1_ff, fs_s2_ff, sd_s1_ff, sd_s2_ff} <= 4'h0;
        end else begin
            {bclk_s1_ff, bclk_s2_ff, bclk_s3_ff} <= {bclk_pin, bclk_s1_ff, bclk_s2_ff};
            {fs_s1_ff, fs_s2_ff} <= {fsync_pin, fs_s1_ff};
            {sd_s1_ff, sd_s2_ff} <= {sdin_pin, sd_s1_ff};
        end
    end

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic                  soft_or_hard;
    asp_state_e            state_ff;
    logic [`ASP_CNT_W-1:0] cnt_ff;
    logic                  ch_right_ff;
    logic                  phase_ff;
    logic                  tx_fresh_ff;
    logic                  rx_unread_ff;

    wire logic                  bclk_rise = bclk_s2_ff & ~bclk_s3_ff;
    wire logic                  bclk_fall = ~bclk_s2_ff & bclk_s3_ff;
    wire logic                  fs_edge   = fs_s2_ff ^ fs_last_ff;
    wire logic                  fs_start  = ctrl.frame_format_select ? (fs_s2_ff & ~fs_last_ff) : fs_edge;
    wire logic                  start     = bclk_rise & ctrl.enable & fs_start;
    wire logic                  start_ch  = ctrl.frame_format_select ? 1'b0 : fs_s2_ff;
    wire logic [`ASP_CNT_W-1:0] wbits     = wlen_bits(ctrl.wlen);
    wire logic [`ASP_CNT_W-1:0] bit_idx   = start ? `ASP_CNT_W'(0) : cnt_ff;
    wire logic                  active    = start | (state_ff == ASP_SHIFT);
    wire logic                  last_bit  = bit_idx == wbits - `ASP_CNT_W'(1);
    wire logic                  word_done = bclk_rise & ctrl.enable & active & last_bit;
    wire logic                  cur_ch    = start ? start_ch : ch_right_ff;
    wire logic                  two_samples_per_pair_on   = ctrl.two_samples_per_pair & (ctrl.wlen == ASP_W16);
    wire logic                  next_right = ctrl.frame_format_select & ~ctrl.mono & ~cur_ch;
    wire logic                  frame_end = word_done & (ctrl.mono ? ~cur_ch : cur_ch);
    wire logic                  xfer_evt  = frame_end & (~two_samples_per_pair_on | phase_ff);
    wire logic                  fs_error  = start & (state_ff == ASP_SHIFT) & ~last_bit;

    assign soft_or_hard = ~nrst | peripheral_reset_control;

    // fsync is tracked only at bclk rises while enabled
    always_ff @(posedge clock) begin
        if (soft_or_hard) begin
            state_ff    <= ASP_IDLE;
            cnt_ff      <= `ASP_CNT_W'(0);
            ch_right_ff <= 1'b0;
            fs_last_ff  <= 1'b0;
        end else if (!ctrl.enable) begin
            state_ff <= ASP_IDLE;
        end else if (bclk_rise) begin
            fs_last_ff <= fs_s2_ff;
            if (word_done) begin
                state_ff    <= next_right ? ASP_SHIFT : ASP_IDLE;
                cnt_ff      <= `ASP_CNT_W'(0);
                ch_right_ff <= next_right;
            end else if (active) begin
                state_ff    <= ASP_SHIFT;
                cnt_ff      <= bit_idx + `ASP_CNT_W'(1);
                ch_right_ff <= cur_ch;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (soft_or_hard || !two_samples_per_pair_on) begin
            phase_ff <= 1'b0;
        end else if (frame_end) begin
            phase_ff <= ~phase_ff;
        end
    end

    // ------------------------------------------------------------
    // transmit word load
    // ------------------------------------------------------------
    // each word loads at its own first rise, so the previous
    // word's lsb still leaves on the fall before it
    wire logic first_bit = bclk_rise & ctrl.enable & active & (bit_idx == `ASP_CNT_W'(0));

    // ------------------------------------------------------------
    // shift registers: kept through software reset
    // ------------------------------------------------------------
    logic [`ASP_WORD_W-1:0] rx_shift_ff;
    logic [`ASP_WORD_W-1:0] tx_shift_ff;

    wire logic [`ASP_WORD_W-1:0] rx_next    = {rx_shift_ff[`ASP_WORD_W-2:0], sd_s2_ff};
    wire logic [`ASP_CNT_W-1:0]  rx_sh      = `ASP_LEN_32 - wbits;
    wire logic [`ASP_WORD_W-1:0] rx_aligned = rx_next << rx_sh;
    wire asp_pair_s              tx_src_l   = tx_data.left;
    wire asp_pair_s              tx_src_r   = tx_data.right;
    wire logic                   load_ch    = cur_ch;
    wire logic                   tx_load    = first_bit;
    wire logic [`ASP_WORD_W-1:0] tx_word    = tx_align(load_ch ? tx_src_r : tx_src_l, ctrl.wlen,
                                                       ctrl.msb_replicate_select, two_samples_per_pair_on, phase_ff);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_shift_ff <= `ASP_WORD_RST;
            tx_shift_ff <= `ASP_WORD_RST;
        end else begin
            if (bclk_rise && ctrl.enable && active) begin
                rx_shift_ff <= rx_next;
            end
            if (tx_load) begin
                tx_shift_ff <= tx_word;
            end else if (bclk_fall) begin
                tx_shift_ff <= tx_shift_ff << 1;
            end
        end
    end

    // ------------------------------------------------------------
    // receive data registers
    // ------------------------------------------------------------
    wire asp_pair_s nxt_rx_pair = rx_place(rx_aligned, ctrl.wlen, ctrl.msb_replicate_select,
                                           two_samples_per_pair_on, phase_ff, cur_ch ? rx_data.right : rx_data.left);

    always_ff @(posedge clock) begin
        if (soft_or_hard) begin
            rx_data <= {2{`ASP_WORD_RST}};
        end else if (word_done && cur_ch) begin
            rx_data.right <= nxt_rx_pair;
        end else if (word_done) begin
            rx_data.left <= nxt_rx_pair;
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    // half a bit behind the receiver: msb leaves on the start rise's fall
    always_ff @(posedge clock) begin
        if (soft_or_hard || !ctrl.enable) begin
            sdout <= 1'b0;
        end else if (bclk_fall) begin
            sdout <= tx_shift_ff[`ASP_WORD_W-1];
        end
    end

    // ------------------------------------------------------------
    // events, flags and cpu interrupt
    // ------------------------------------------------------------
    wire logic     ou_err  = xfer_evt & (~tx_fresh_ff | rx_unread_ff);
    asp_irq_s      set_flags;
    asp_irq_s      nxt_flags;

    assign set_flags.overrun_underrun_error = ou_err;
    assign set_flags.fsync_error            = fs_error;
    assign set_flags.rx_stereo              = xfer_evt & ~ctrl.mono;
    assign set_flags.tx_stereo              = xfer_evt & ~ctrl.mono;
    assign set_flags.rx_mono                = xfer_evt & ctrl.mono;
    assign set_flags.tx_mono                = xfer_evt & ctrl.mono;
    // read clears what it returns; a new set wins
    assign nxt_flags = (interrupt_flag_reg & ~(flag_read ? interrupt_flag_reg : `ASP_FLAGS_RST))
                       | set_flags;

    always_ff @(posedge clock) begin
        if (soft_or_hard) begin
            interrupt_flag_reg <= `ASP_FLAGS_RST;
            cpu_irq            <= 1'b0;
            tx_dma_evt         <= 1'b0;
            rx_dma_evt         <= 1'b0;
        end else begin
            interrupt_flag_reg <= nxt_flags;
            cpu_irq            <= |(nxt_flags & interrupt_mask_reg);
            tx_dma_evt         <= xfer_evt;
            rx_dma_evt         <= xfer_evt;
        end
    end

    // host handshake state for overrun and underrun; set wins
    always_ff @(posedge clock) begin
        if (soft_or_hard) begin
            tx_fresh_ff  <= 1'b0;
            rx_unread_ff <= 1'b0;
        end else begin
            tx_fresh_ff  <= tx_data_valid | (tx_fresh_ff & ~xfer_evt);
            rx_unread_ff <= xfer_evt | (rx_unread_ff & ~rx_data_read);
        end
    end

endmodule
`default_nettype wire

/* File: verification/asp_word_two_samples_per_pair_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_word_two_samples_per_pair_sva
    import asp_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        peripheral_reset_control,
    input wire asp_ctrl_s   ctrl,
    input wire asp_irq_s    interrupt_mask_reg,
    input wire logic        flag_read,
    input wire logic        sdout,
    input wire asp_stereo_s rx_data,
    input wire asp_irq_s    interrupt_flag_reg,
    input wire logic        cpu_irq,
    input wire logic        tx_dma_evt,
    input wire logic        rx_dma_evt
);
    // ------
    // checks
    // ------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_read_quiet;
        flag_read ##1 (!rx_dma_evt && !tx_dma_evt);
    endsequence
    a_hw_reset: assert property (disable iff (1'b0) !nrst |=> rx_data == '0 && interrupt_flag_reg == '0
        && !cpu_irq && !sdout && !rx_dma_evt && !tx_dma_evt) else $error("outputs not cleared by reset");
    a_soft_reset: assert property (peripheral_reset_control |=> rx_data == '0
        && interrupt_flag_reg == '0 && !cpu_irq) else $error("outputs not cleared by soft reset");
    a_dma_one_cycle: assert property (rx_dma_evt |=> !rx_dma_evt) else $error("rx event not a pulse");
    a_rx_stereo_flag: assert property (rx_dma_evt && !ctrl.mono |-> interrupt_flag_reg.rx_stereo)
        else $error("rx stereo flag missing");
    a_rx_mono_flag: assert property (rx_dma_evt && ctrl.mono |-> interrupt_flag_reg.rx_mono)
        else $error("rx mono flag missing");
    a_tx_event_flag: assert property (tx_dma_evt |-> (ctrl.mono ? interrupt_flag_reg.tx_mono
        : interrupt_flag_reg.tx_stereo)) else $error("tx flag missing");
    a_irq_from_flags: assert property (cpu_irq == |(interrupt_flag_reg & $past(interrupt_mask_reg)))
        else $error("cpu irq disagrees with flags and mask");
    a_flag_sticky: assert property (!flag_read && !peripheral_reset_control |=>
        (interrupt_flag_reg & $past(interrupt_flag_reg)) == $past(interrupt_flag_reg)) else $error("flag lost");
    a_read_clears: assert property (s_read_quiet |-> {interrupt_flag_reg.rx_stereo,
        interrupt_flag_reg.tx_stereo, interrupt_flag_reg.rx_mono, interrupt_flag_reg.tx_mono} == 4'h0)
        else $error("flags not cleared by read");
    a_off_quiet: assert property (!ctrl.enable [*3] |-> !sdout && !rx_dma_evt && !tx_dma_evt)
        else $error("disabled port active");
endmodule
bind asp_word_two_samples_per_pair asp_word_two_samples_per_pair_sva u_sva (.clock(clock), .nrst(nrst),
    .peripheral_reset_control(peripheral_reset_control), .ctrl(ctrl), .interrupt_mask_reg(interrupt_mask_reg),
    .flag_read(flag_read), .sdout(sdout), .rx_data(rx_data), .interrupt_flag_reg(interrupt_flag_reg),
    .cpu_irq(cpu_irq), .tx_dma_evt(tx_dma_evt), .rx_dma_evt(rx_dma_evt));
`default_nettype wire

/* File: verification/asp_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_codec_model (
    input  wire logic  sdout,
    output logic       bclk_pin = 1'b0,
    output logic       fsync_pin = 1'b0,
    output logic       sdin_pin = 1'b0,
    output logic [63:0] heard = 64'h0
);
    // ---------------------------------------------
    // dsp or i2s frame, msb first, bclk still between frames
    // ---------------------------------------------
    bit i2s_mode = 1'b0;
    task automatic frame(input logic [63:0] words, input int n, input bit st);
        for (int k = 0; k < (st ? 2 : 1) * n; k++) begin
            sdin_pin = words[(1 - k / n) * 32 + n - 1 - k % n];
            fsync_pin = i2s_mode ? (k >= n) : (k == 0);
            #40 bclk_pin = 1'b1;
            #80 bclk_pin = 1'b0;
            #40 heard = {heard[62:0], sdout};
        end
        sdin_pin = ~sdin_pin;
    endtask
endmodule
`default_nettype wire

/* File: verification/test_audio_serial_word_packing_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module test_audio_serial_word_packing_irq
    import asp_pkg::*;
;
    logic        clock, nrst, prc, tdv, rdr, frd, cpu_irq, tx_evt, rx_evt;
    wire         bclk, fsync, sdin, sdout;
    asp_ctrl_s   ctrl;
    asp_irq_s    mask, flags;
    asp_stereo_s tx_data, rx_data;
    logic [63:0] heard;
    int          checked = 0, miscompares = 0, n_rx = 0, n_tx = 0, r0, t0;
    int          ns[5] = '{16, 18, 20, 24, 32};
    asp_word_two_samples_per_pair dut (.clock(clock), .nrst(nrst), .peripheral_reset_control(prc), .ctrl(ctrl),
        .interrupt_mask_reg(mask), .tx_data(tx_data), .tx_data_valid(tdv), .rx_data_read(rdr),
        .flag_read(frd), .bclk_pin(bclk), .fsync_pin(fsync), .sdin_pin(sdin), .sdout(sdout), .rx_data(rx_data),
        .interrupt_flag_reg(flags), .cpu_irq(cpu_irq), .tx_dma_evt(tx_evt), .rx_dma_evt(rx_evt));
    asp_codec_model codec (.sdout(sdout), .bclk_pin(bclk), .fsync_pin(fsync), .sdin_pin(sdin), .heard(heard));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rx_evt === 1'b1) n_rx++;
        if (tx_evt === 1'b1) n_tx++;
    end
    // -------
    // helpers
    // -------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        tick(12);
        nrst = 1'b1;
        tick(3);
    endtask
    function automatic logic [31:0] expw(input logic [31:0] s, input int n, input bit sx);
        logic signed [31:0] v;
        v = s << (32 - n);
        return (sx && n != 16) ? v >>> (32 - n) : v;
    endfunction
    function automatic logic [63:0] mk(input int b);
        return (64'h1 << b) - 64'h1;
    endfunction
    task automatic setup(input int w, input bit sx, input bit pk, input bit mo);
        ctrl = '{enable: 1'b1, mono: mo, frame_format_select: 1'b1, two_samples_per_pair: pk,
                 msb_replicate_select: sx, wlen: asp_wlen_e'(w)};
        tick(1);
    endtask
    task automatic run(input logic [63:0] words, input int n, input bit st, input bit host, input int evts);
        r0 = n_rx;
        t0 = n_tx;
        tdv = host;
        rdr = host;
        tick(1);
        tdv = 1'b0;
        rdr = 1'b0;
        codec.frame(words, n, st);
        tick(4);
        check("rx events", n_rx - r0, evts);
        check("tx events", n_tx - t0, evts);
    endtask
    task automatic rd();
        frd = 1'b1;
        tick(1);
        frd = 1'b0;
        tick(1);
        check("flags after read", {flags, cpu_irq}, 7'h00);
    endtask
    // ---------
    // scenarios
    // ---------
    task automatic t_layout();
        logic [31:0] l, r;
        int          n;
        for (int i = 0; i < 5; i++) begin
            for (int sx = 0; sx < 2; sx++) begin
                n = ns[i];
                l = 32'hd16aee09 >> (32 - n);
                r = ~l & (32'hffffffff >> (32 - n));
                setup(i, sx[0], 1'b0, 1'b0);
                tx_data = {expw(l, n, sx[0]), expw(r, n, sx[0])};
                run({l, r}, n, 1'b1, 1'b1, 1);
                check("rx left", rx_data.left, expw(l, n, sx[0]));
                check("rx right", rx_data.right, expw(r, n, sx[0]));
                check("tx bits", heard & mk(2 * n), (({32'h0, l} << n) | r) & mk(2 * n));
                check("stereo flag", flags.rx_stereo, 1'b1);
                check("masked irq", cpu_irq, 1'b0);
                rd();
            end
        end
        $display("layout test done");
    endtask
    task automatic t_two_samples_per_pair();
        setup(0, 1'b0, 1'b1, 1'b0);
        tx_data = {16'h29cc, 16'h8001, 16'h7ade, 16'hf00f};
        run({32'h29cc, 32'h7ade}, 16, 1'b1, 1'b1, 0);
        run({32'h8001, 32'hf00f}, 16, 1'b1, 1'b1, 1);
        check("packed rx", rx_data, {16'h29cc, 16'h8001, 16'h7ade, 16'hf00f});
        check("packed tx", heard, 64'h29cc_7ade_8001_f00f);
        rd();
        $display("two_samples_per_pair test done");
    endtask
    task automatic t_mono();
        setup(3, 1'b0, 1'b0, 1'b1);
        mask = '{rx_mono: 1'b1, default: 1'b0};
        tx_data = {32'h98a31100, 32'h0};
        run({32'h0098a311, 32'h0}, 24, 1'b0, 1'b1, 1);
        check("mono rx", rx_data.left, 32'h98a31100);
        check("mono tx", heard[23:0], 24'h98a311);
        check("mono flags", {flags.rx_mono, flags.rx_stereo}, 2'b10);
        check("mono irq", cpu_irq, 1'b1);
        rd();
        run({32'h00123456, 32'h0}, 24, 1'b0, 1'b0, 1);
        check("error flag", flags.overrun_underrun_error, 1'b1);
        mask = '0;
        rd();
        $display("mono test done");
    endtask
    task automatic t_reset();
        setup(0, 1'b0, 1'b0, 1'b0);
        run({32'h1234, 32'h5678}, 16, 1'b1, 1'b1, 1);
        prc = 1'b1;
        tick(1);
        prc = 1'b0;
        check("soft reset", {rx_data, flags, cpu_irq}, 71'h0);
        run({32'h1234, 32'h5678}, 16, 1'b1, 1'b0, 1);
        do_reset();
        check("hard reset", {rx_data, flags, cpu_irq, sdout}, 72'h0);
        $display("reset test done");
    endtask
    task automatic t_i2s();
        setup(0, 1'b0, 1'b0, 1'b0);
        ctrl.frame_format_select = 1'b0;
        codec.i2s_mode = 1'b1;
        tx_data = {32'h5a5a0000, 32'hc3c3a5a5};
        run({32'h1234, 32'h5678}, 16, 1'b1, 1'b1, 1);
        check("i2s first right", rx_data.right, 32'h5678_0000);
        run({32'h9abc, 32'hdef0}, 16, 1'b1, 1'b1, 1);
        check("i2s rx", rx_data, {32'h9abc_0000, 32'hdef0_0000});
        check("i2s tx", heard[31:0], 32'h5a5a_c3c3);
        prc = 1'b1;
        tick(1);
        prc = 1'b0;
        ctrl.wlen = ASP_W18;
        run({32'h1, 32'h2}, 16, 1'b1, 1'b1, 0);
        check("kept shift word", heard[31:16], 16'ha5a5);
        run({32'h1, 32'h2}, 16, 1'b1, 1'b1, 0);
        check("sync error flag", flags.fsync_error, 1'b1);
        $display("i2s test done");
    endtask
    initial begin
        {nrst, prc, tdv, rdr, frd} = 5'h00;
        ctrl = '0;
        mask = '0;
        tx_data = '0;
        do_reset();
        check("reset outputs", {rx_data, flags, cpu_irq, sdout, tx_evt, rx_evt}, 74'h0);
        t_layout();
        t_two_samples_per_pair();
        t_mono();
        t_reset();
        t_i2s();
        results();
    end
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
